/* src/bms_regs.svh */
// Constants of the backup mode sequencer
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH
`define BMS_STANDBY_SELECT_STOP      1'h0
`define BMS_STANDBY_SELECT_SLEEP     1'h1
`define BMS_GEAR_UNDIV     3'h0
`define BMS_WUP_SHIFT      4
`define BMS_WUP_W          12
`define BMS_WUP_CNT_W      16
`define BMS_OSC_STABLE_CYC 16'h0010
`define BMS_PINS           8
`define BMS_SRC_W          11
`define BMS_SRC_RESET      0
`define BMS_SRC_EXT0       1
`define BMS_SRC_EXT8       6
`define BMS_SRC_KEY_STATIC 7
`define BMS_SRC_KEY_DYN    8
`define BMS_SRC_CAL        9
`define BMS_SRC_RMC        10
`endif

/* src/bms_pkg.sv */
// Types of the backup mode sequencer
`default_nettype none
`include "bms_regs.svh"
package bms_pkg;
    typedef enum logic [2:0] {
        BMS_RUN    = 3'h0,
        BMS_BACKUP = 3'h1,
        BMS_OSC    = 3'h3,
        BMS_WARM   = 3'h2
    } bms_state_t;
    typedef struct packed {
        logic       reset;
        logic [5:0] ext_irq;
        logic       key_static;
        logic       key_dynamic;
        logic       calendar;
        logic [1:0] remote_rx;
    } bms_wake_t;
    typedef struct packed {
        logic [`BMS_PINS-1:0] in_en;
        logic [`BMS_PINS-1:0] out_en;
    } bms_port_t;
endpackage
`default_nettype wire

/* src/bms_sync.sv */
// Three-stage input synchroniser with agreement filter
`default_nettype none
module bms_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_dout;

    always_comb begin
        next_dout = dout;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_dout[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s1   <= '0;
            s2   <= '0;
            s3   <= '0;
            dout <= '0;
        end else begin
            s1   <= din;
            s2   <= s1;
            s3   <= s2;
            dout <= next_dout;
        end
    end
endmodule
`default_nettype wire

/* src/bms_top.sv */
// Backup mode entry and exit sequencer
// Summary of operation
// - Backup with drive enable: pin paths follow per-pin enables and controls.
// - Pin functions unavailable in the backup mode have input and output disabled.
// - Dedicated input pins keep input gates and pulls active in backup.
// - Stop drives both oscillator outputs high; sleep only the high-speed one.
// - Low-speed oscillator runs outside backup and in backup sleep; stop shuts it off.
// - Standby select picks backup stop or backup sleep.
// - Backup entry breaks the debug probe connection.
// - Stop wakes on external reset, external irq lines, static key event.
// - Sleep also wakes on dynamic key, calendar and both remote events.
// - Wake by external reset preserves no backup RAM or calendar state.
// - Accepted wake restores regulator power and restarts high-speed oscillator.
// - Warm-up starts after stable oscillation; internal reset held low throughout.
// - After warm-up, release internal reset and return to prior mode.
// - Level wake must hold through warm-up, else fall back into backup.
// - Reset cause flags show which wake source ended backup.
`default_nettype none
`include "bms_regs.svh"
module bms_top (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     wait_for_interrupt_instr,
    input  wire logic                     standby_select,
    input  wire logic                     port_hold,
    input  wire logic                     drive_enable,
    input  wire logic                     low_speed_osc_enable,
    input  wire logic                     pll_on_a,
    input  wire logic [2:0]               clock_gear,
    input  wire logic [`BMS_WUP_W-1:0]    warmup_count,
    input  wire logic                     osc_stable,
    input  wire bms_pkg::bms_wake_t       wake_in,
    input  wire bms_pkg::bms_port_t       port_cfg,
    input  wire logic [`BMS_PINS-1:0]     port_avail_sleep,
    input  wire logic [`BMS_PINS-1:0]     port_avail_stop,
    input  wire logic                     cause_clear,
    output logic                          in_backup,
    output logic                          regulator_on,
    output logic                          high_speed_osc_run,
    output logic                          high_speed_osc_out_high,
    output logic                          low_speed_osc_run,
    output logic                          low_speed_osc_out_high,
    output logic                          domain_reset_n,
    output logic                          debug_probe_disconnect,
    output logic                          dedicated_inputs_on,
    output logic                          memory_state_lost,
    output logic                          entry_refused,
    output bms_pkg::bms_port_t            port_gate,
    output logic [`BMS_SRC_W-1:0]         reset_cause_flags
);
    import bms_pkg::*;

    // ----------------------------------------
    // Wake input synchronisation
    // ----------------------------------------
    bms_wake_t wake_s;

    bms_sync #(.W($bits(bms_wake_t))) u_sync (
        .clock (clock),
        .rst   (rst),
        .din   (wake_in),
        .dout  (wake_s)
    );

    // ----------------------------------------
    // Wake qualification
    // ----------------------------------------
    logic                  mode_sleep;
    logic [`BMS_SRC_W-1:0] src_vec;
    logic [`BMS_SRC_W-1:0] allow_vec;
    logic [`BMS_SRC_W-1:0] hit_vec;
    logic                  wake_hit;

    always_comb begin
        src_vec = {wake_s.remote_rx[0] | wake_s.remote_rx[1], wake_s.calendar,
                   wake_s.key_dynamic, wake_s.key_static, wake_s.ext_irq, wake_s.reset};
        allow_vec = '1;
        if (!mode_sleep) begin
            allow_vec[`BMS_SRC_KEY_DYN] = 1'b0;
            allow_vec[`BMS_SRC_CAL]     = 1'b0;
            allow_vec[`BMS_SRC_RMC]     = 1'b0;
        end
        hit_vec  = src_vec & allow_vec;
        wake_hit = |hit_vec[`BMS_SRC_W-1:1];
    end

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    bms_state_t                 state;
    bms_state_t                 next_state;
    logic [`BMS_WUP_CNT_W-1:0]  cnt;
    logic [`BMS_WUP_CNT_W-1:0]  next_cnt;
    logic                       next_mode_sleep;
    logic [`BMS_SRC_W-1:0]      next_cause;
    logic [`BMS_SRC_W-1:0]      held_src;
    logic [`BMS_SRC_W-1:0]      next_held_src;
    logic                       next_lost;
    logic                       next_refused;
    logic                       prep_ok;

    always_comb begin
        prep_ok         = port_hold && !pll_on_a && (clock_gear == `BMS_GEAR_UNDIV);
        next_state      = state;
        next_cnt        = cnt;
        next_mode_sleep = mode_sleep;
        next_held_src   = held_src;
        next_cause      = reset_cause_flags;
        next_lost       = memory_state_lost;
        next_refused    = 1'b0;
        if (cause_clear) begin
            next_cause = '0;
        end
        case (state)
            BMS_RUN: begin
                if (wait_for_interrupt_instr) begin
                    if (prep_ok) begin
                        next_state      = BMS_BACKUP;
                        next_mode_sleep = standby_select;
                    end else begin
                        next_refused = 1'b1;
                    end
                end
            end
            BMS_BACKUP: begin
                if (wake_s.reset) begin
                    next_state = BMS_RUN;
                    next_lost  = 1'b1;
                    next_cause = {{(`BMS_SRC_W-1){1'b0}}, 1'b1};
                end else if (wake_hit) begin
                    next_state    = BMS_OSC;
                    next_held_src = hit_vec;
                end
            end
            BMS_OSC: begin
                if (osc_stable) begin
                    next_state = BMS_WARM;
                    next_cnt   = {warmup_count, {`BMS_WUP_SHIFT{1'b0}}};
                end
            end
            BMS_WARM: begin
                if ((hit_vec & held_src) == '0) begin
                    next_state = BMS_BACKUP;
                end else if (cnt <= 16'h0001) begin
                    next_state = BMS_RUN;
                    next_cause = held_src;
                end else begin
                    next_cnt = cnt - 16'h0001;
                end
            end
            default: next_state = BMS_RUN;
        endcase
        if (state == BMS_RUN && wait_for_interrupt_instr && prep_ok) begin
            next_lost = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state             <= BMS_RUN;
            cnt               <= '0;
            mode_sleep        <= 1'b0;
            held_src          <= '0;
            reset_cause_flags <= '0;
            memory_state_lost <= 1'b0;
            entry_refused     <= 1'b0;
        end else begin
            state             <= next_state;
            cnt               <= next_cnt;
            mode_sleep        <= next_mode_sleep;
            held_src          <= next_held_src;
            reset_cause_flags <= next_cause;
            memory_state_lost <= next_lost;
            entry_refused     <= next_refused;
        end
    end

    // ----------------------------------------
    // Power, clock and pin controls
    // ----------------------------------------
    logic      n_backup;
    logic      n_regulator;
    logic      n_hs_run;
    logic      n_hs_high;
    logic      n_ls_run;
    logic      n_ls_high;
    logic      n_dom_rst_n;
    logic      n_dbg_disc;
    bms_port_t n_gate;
    logic      n_sleep;

    always_comb begin
        n_sleep     = next_mode_sleep;
        n_backup    = (next_state != BMS_RUN);
        n_regulator = (next_state != BMS_BACKUP);
        n_hs_run    = (next_state != BMS_BACKUP);
        n_hs_high   = (next_state == BMS_BACKUP);
        n_ls_run    = low_speed_osc_enable && (!n_backup || n_sleep);
        n_ls_high   = n_backup && !n_sleep;
        n_dom_rst_n = (next_state == BMS_RUN);
        n_dbg_disc  = n_backup ? 1'b1 : (debug_probe_disconnect && !wait_for_interrupt_instr);
        if (!n_backup) begin
            n_gate.in_en  = port_cfg.in_en;
            n_gate.out_en = port_cfg.out_en;
        end else if (n_sleep) begin
            n_gate.in_en  = port_cfg.in_en & port_avail_sleep;
            n_gate.out_en = port_cfg.out_en & port_avail_sleep;
        end else if (drive_enable) begin
            n_gate.in_en  = port_cfg.in_en & port_avail_stop;
            n_gate.out_en = port_cfg.out_en & port_avail_stop;
        end else begin
            n_gate.in_en  = '0;
            n_gate.out_en = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            in_backup               <= 1'b0;
            regulator_on            <= 1'b1;
            high_speed_osc_run      <= 1'b1;
            high_speed_osc_out_high <= 1'b0;
            low_speed_osc_run       <= 1'b0;
            low_speed_osc_out_high  <= 1'b0;
            domain_reset_n          <= 1'b0;
            debug_probe_disconnect  <= 1'b0;
            dedicated_inputs_on     <= 1'b1;
            port_gate               <= '0;
        end else begin
            in_backup               <= n_backup;
            regulator_on            <= n_regulator;
            high_speed_osc_run      <= n_hs_run;
            high_speed_osc_out_high <= n_hs_high;
            low_speed_osc_run       <= n_ls_run;
            low_speed_osc_out_high  <= n_ls_high;
            domain_reset_n          <= n_dom_rst_n;
            debug_probe_disconnect  <= n_dbg_disc;
            dedicated_inputs_on     <= 1'b1;
            port_gate               <= n_gate;
        end
    end
endmodule
`default_nettype wire

/* verification/bms_top_chk.sv */
// Port assertions for the backup mode sequencer
`default_nettype none
`include "bms_regs.svh"
module bms_top_chk (
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic                  wait_for_interrupt_instr,
    input wire logic                  standby_select,
    input wire logic                  port_hold,
    input wire logic                  drive_enable,
    input wire logic                  pll_on_a,
    input wire logic [2:0]            clock_gear,
    input wire bms_pkg::bms_wake_t    wake_in,
    input wire logic                  in_backup,
    input wire logic                  regulator_on,
    input wire logic                  high_speed_osc_run,
    input wire logic                  high_speed_osc_out_high,
    input wire logic                  low_speed_osc_run,
    input wire logic                  low_speed_osc_out_high,
    input wire logic                  domain_reset_n,
    input wire logic                  debug_probe_disconnect,
    input wire logic                  entry_refused,
    input wire bms_pkg::bms_port_t    port_gate,
    input wire logic [`BMS_SRC_W-1:0] reset_cause_flags
);
    import bms_pkg::*;
    // ------------------------------
    // Entry, wake and exit checks
    // ------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence ready_s;
        wait_for_interrupt_instr && !in_backup && port_hold && !pll_on_a && clock_gear == 3'h0;
    endsequence
    sequence stop_idle_s;
        in_backup && low_speed_osc_out_high && !regulator_on ##1
        (!regulator_on && !(wake_in.reset || |wake_in.ext_irq || wake_in.key_static)) [*8];
    endsequence
    sequence wake_held_s;
        in_backup && !regulator_on && |wake_in.ext_irq ##1 (|wake_in.ext_irq) [*6];
    endsequence
    entry_taken_a: assert property (ready_s |=> in_backup && !domain_reset_n)
        else $error("entry not taken");
    entry_refuse_a: assert property (wait_for_interrupt_instr && !in_backup &&
        (!port_hold || pll_on_a || clock_gear != 3'h0) |=> entry_refused && !in_backup)
        else $error("bad entry not refused");
    stop_osc_a: assert property (ready_s ##0 standby_select == `BMS_STANDBY_SELECT_STOP |=>
        high_speed_osc_out_high && low_speed_osc_out_high && !low_speed_osc_run)
        else $error("stop oscillator pins wrong");
    sleep_osc_a: assert property (ready_s ##0 standby_select == `BMS_STANDBY_SELECT_SLEEP |=>
        high_speed_osc_out_high && !low_speed_osc_out_high)
        else $error("sleep oscillator pins wrong");
    probe_cut_a: assert property ($rose(in_backup) |-> debug_probe_disconnect)
        else $error("probe not cut");
    domain_held_a: assert property (in_backup |-> !domain_reset_n)
        else $error("domain reset released in backup");
    wake_power_a: assert property (wake_held_s |-> ##[0:3] (regulator_on && high_speed_osc_run))
        else $error("wake did not restart power");
    stop_ignore_a: assert property (stop_idle_s |=> !regulator_on && in_backup)
        else $error("unlisted event woke stop");
    stop_gate_a: assert property (in_backup && $past(in_backup) && low_speed_osc_out_high &&
        !regulator_on && !$past(drive_enable) |-> port_gate == '0)
        else $error("port paths open in stop");
    exit_cause_a: assert property ($fell(in_backup) && !$past(rst) |->
        reset_cause_flags != '0 && domain_reset_n)
        else $error("exit without cause");
endmodule
bind bms_top bms_top_chk bms_top_chk_inst (
    .clock, .rst, .wait_for_interrupt_instr, .standby_select, .port_hold, .drive_enable,
    .pll_on_a, .clock_gear, .wake_in, .in_backup, .regulator_on, .high_speed_osc_run,
    .high_speed_osc_out_high, .low_speed_osc_run, .low_speed_osc_out_high, .domain_reset_n,
    .debug_probe_disconnect, .entry_refused, .port_gate, .reset_cause_flags
);
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the backup mode sequencer
`default_nettype none
`include "bms_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import bms_pkg::*;
    // ------------------------------
    // Stimulus, scoreboard and checks
    // ------------------------------
    logic        clock, rst, wait_for_interrupt_instr, standby_select, port_hold;
    logic        drive_enable, low_speed_osc_enable, pll_on_a, osc_stable, cause_clear;
    logic [2:0]  clock_gear;
    logic [11:0] warmup_count;
    bms_wake_t   wake_in;
    bms_port_t   port_cfg, port_gate;
    logic [7:0]  port_avail_sleep, port_avail_stop;
    logic        in_backup, regulator_on, high_speed_osc_run, high_speed_osc_out_high;
    logic        low_speed_osc_run, low_speed_osc_out_high, domain_reset_n;
    logic        debug_probe_disconnect, dedicated_inputs_on, memory_state_lost;
    logic        entry_refused, was_backup;
    logic [10:0] reset_cause_flags;
    int          failures, total_checks, seed, n, wcyc;
    int          expq[$];
    logic [10:0] flq[$];
    bms_top bms_top_inst (.*);
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wait_out(input logic bk, input logic v);
        for (int i = 0; i < 13000 && (bk ? in_backup : regulator_on) !== v; i++)
            @(negedge clock);
        chk(bk ? in_backup : regulator_on, v, "wait");
    endtask
    task automatic enter(input logic mode);
        standby_select = mode;
        wait_for_interrupt_instr = 1'h1;
        @(negedge clock);
        wait_for_interrupt_instr = 1'h0;
    endtask
    task automatic exitw(input logic [10:0] f);
        flq.push_back(f);
        expq.push_back(int'(warmup_count) * 16);
        wait_out(1'h0, 1'h1);
        chk(high_speed_osc_run, 1'h1, "osc");
        osc_stable = 1'h1;
        wait_out(1'h1, 1'h0);
        osc_stable = 1'h0;
        wake_in = '0;
        chk({domain_reset_n, dedicated_inputs_on}, 2'h3, "exit");
        repeat (5) @(negedge clock);
    endtask
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        if (was_backup && !in_backup && !rst && flq.size() > 0) begin
            chk(reset_cause_flags, flq.pop_front(), "cause");
            chk(wcyc >= expq[0] && wcyc <= expq[0] + 3, 1'h1, "warm");
            void'(expq.pop_front());
        end
        wcyc = (!in_backup || !regulator_on) ? 0 : wcyc + (osc_stable ? 1 : 0);
        was_backup = in_backup;
    end
    initial begin
        {rst, port_hold, low_speed_osc_enable} = 3'h7;
        {wait_for_interrupt_instr, standby_select, drive_enable, pll_on_a} = 4'h0;
        {osc_stable, cause_clear, clock_gear, wake_in, port_cfg} = '0;
        {port_avail_sleep, port_avail_stop} = 16'h0;
        warmup_count = 12'h2F4;
        seed = 28;
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst = 1'h0;
        @(negedge clock);
        for (int i = 0; i < 3; i++) begin
            port_hold = (i != 0);
            pll_on_a = (i == 1);
            clock_gear = (i == 2) ? 3'h1 + 3'($unsigned($random(seed)) % 7) : 3'h0;
            enter(`BMS_STANDBY_SELECT_STOP);
            chk({entry_refused, in_backup}, 2'h2, "refuse");
            @(negedge clock);
        end
        {port_hold, pll_on_a, clock_gear} = 5'h10;
        $display("done refusals");
        port_cfg = 16'($random(seed));
        enter(`BMS_STANDBY_SELECT_STOP);
        chk({in_backup, high_speed_osc_out_high, low_speed_osc_out_high, low_speed_osc_run,
             debug_probe_disconnect, domain_reset_n, port_gate}, {6'h3A, 16'h0}, "stop");
        {wake_in.key_dynamic, wake_in.calendar, wake_in.remote_rx} = 4'hF;
        repeat (12) @(negedge clock);
        chk({in_backup, regulator_on}, 2'h2, "ignored");
        wake_in = '0;
        @(negedge clock);
        n = $unsigned($random(seed)) % 6;
        wake_in.ext_irq[n] = 1'h1;
        exitw(11'h1 << (n + 1));
        $display("done stop");
        drive_enable = 1'h1;
        port_cfg = 16'($random(seed));
        port_avail_sleep = 8'($random(seed));
        port_avail_stop = 8'($random(seed));
        enter(`BMS_STANDBY_SELECT_SLEEP);
        chk({high_speed_osc_out_high, low_speed_osc_out_high, low_speed_osc_run, port_gate},
            {3'h5, port_cfg & {2{port_avail_sleep}}}, "sleep");
        wake_in.calendar = 1'h1;
        wait_out(1'h0, 1'h1);
        osc_stable = 1'h1;
        repeat (5) @(negedge clock);
        wake_in = '0;
        repeat (60) @(negedge clock);
        chk({in_backup, domain_reset_n}, 2'h2, "fallback");
        wake_in.remote_rx = 2'h2;
        exitw(11'h1 << `BMS_SRC_RMC);
        $display("done sleep");
        enter(`BMS_STANDBY_SELECT_STOP);
        chk(port_gate, port_cfg & {2{port_avail_stop}}, "drive");
        wake_in.reset = 1'h1;
        flq.push_back(11'h001);
        expq.push_back(0);
        wait_out(1'h1, 1'h0);
        wake_in = '0;
        chk(memory_state_lost, 1'h1, "lost");
        cause_clear = 1'h1;
        @(negedge clock);
        cause_clear = 1'h0;
        @(negedge clock);
        chk(reset_cause_flags, 11'h000, "clear");
        port_hold = 1'h0;
        @(negedge clock);
        chk(port_gate, port_cfg, "ports");
        $display("done reset wake");
        results();
    end
    initial begin
        repeat (30000) @(posedge clock);
        failures++;
        results();
    end
endmodule
`default_nettype wire
